// *** core/smd_consts.svh ***
// Constants for the servo monitor display block
`ifndef SMD_CONSTS_SVH
`define SMD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SMD_OFS_CTRL        12'h000
`define SMD_OFS_INT_STATUS  12'h004
`define SMD_OFS_INT_MASK    12'h008
`define SMD_OFS_SINGLE_TURN 12'h00c
`define SMD_OFS_TURN_COUNT  12'h010
`define SMD_OFS_CAUSE       12'h014
`define SMD_OFS_LOAD        12'h018
`define SMD_OFS_LOAD_LIMIT  12'h01c
`define SMD_OFS_VIEW        12'h020

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SMD_CTRL_SEL_LSB    0
`define SMD_CTRL_SEL_MSB    5
`define SMD_CTRL_LIMIT_BIT  8
`define SMD_CTRL_CLAMP_BIT  9
`define SMD_CTRL_IOPAGE_BIT 10
`define SMD_CTRL_RESTART    11

// ----------------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------------
`define SMD_INT_TURN_UP     0
`define SMD_INT_TURN_DOWN   1
`define SMD_INT_REGEN       2
`define SMD_INT_OVERLOAD    3
`define SMD_INT_CAUSE       4
`define SMD_INT_W           5

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define SMD_SEL_DEFAULT     6'h22
`define SMD_SEL_MAX         6'h2a
`define SMD_LIMIT_DEFAULT   8'h64
`define SMD_SINGLE_MAX      23'h7fffff
`define SMD_HALF_TURN       23'h400000

// ----------------------------------------------------------------------------
// Segment patterns, bit order {g,f,e,d,c,b,a}
// ----------------------------------------------------------------------------
`define SMD_SEG_UPPER       7'h23
`define SMD_SEG_LOWER       7'h1c
`define SMD_SEG_BLANK       7'h00
`define SMD_SEG_C           7'h58
`define SMD_SEG_P           7'h73
`define SMD_DIGITS          10

`endif

// *** core/smd_pkg.sv ***
// Types shared by the servo monitor display block
package smd_pkg;

	typedef enum logic [5:0] {
		SMD_ITEM_DEVIATION = 6'h00,
		SMD_ITEM_SPEED     = 6'h01,
		SMD_ITEM_IO        = 6'h0a,
		SMD_ITEM_CAUSE     = 6'h11,
		SMD_ITEM_SINGLE    = 6'h15,
		SMD_ITEM_TURNS     = 6'h16,
		SMD_ITEM_SERVO     = 6'h22,
		SMD_ITEM_DICT      = 6'h2a
	} smd_item_e;

	typedef enum logic [2:0] {
		SMD_APB_IDLE   = 3'b001,
		SMD_APB_SETUP  = 3'b010,
		SMD_APB_ACCESS = 3'b100
	} smd_apb_e;

	typedef logic [6:0] smd_seg_t;

endpackage : smd_pkg

// *** core/smd_monitor.sv ***
// Front-panel monitor: I/O view, no-run cause, encoder turns, APB registers
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "smd_consts.svh"

// Operation
// - Active line lights upper half of its digit, inactive line the lower half.
// - Decimal point lit on digits showing inputs, dark on digits showing outputs.
// - Input lines one to ten placed from rightmost digit leftward.
// - Output lines one to ten placed rightmost leftward with decimal points dark.
// - Single-turn position spans 0 to 8388607 for the 23-bit encoder.
// - Counter-clockwise motion counts positive, clockwise motion negative.
// - Crossing above 8388607 adds a turn, crossing below 0 subtracts one.
// - Turn count is signed 16-bit and wraps at both ends.
// - Power-on selection accepts 0 to 42, defaults to 34, applies after restart.
// - Each selection value maps to one monitor item; unused values show nothing. Only 0x0a, 0x11, 0x15, 0x16 and 0x22 show an item here.
// - No-run cause is a numbered code from 1 to 13.
// - Code 3 when limit setting is 0 and the commanded-direction limit is open.
// - Code 9 when zero-clamp setting is 1 and the clamp input is open.
// - Regenerative load factor exposed in percent; rising factor raises its alarm.
// - Overload factor exposed in percent; rising factor raises its alarm.
// - Negative signed values light decimal points of the two leftmost digits.
module smd_monitor
	import smd_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	output logic              irq,
	input  wire logic [9:0]   input_lines,
	input  wire logic [9:0]   output_lines,
	input  wire logic [22:0]  enc_position,
	input  wire logic         enc_strobe,
	input  wire logic         bus_undervoltage,
	input  wire logic         servo_on_input,
	input  wire logic         positive_limit_input,
	input  wire logic         negative_limit_input,
	input  wire logic         drive_alarm,
	input  wire logic         relay_closed,
	input  wire logic         estop_input,
	input  wire logic         cmd_dir_negative,
	input  wire logic         pos_cmd_low,
	input  wire logic         torque_limited,
	input  wire logic         zero_clamp_closed,
	input  wire logic         vel_cmd_low,
	input  wire logic         torque_cmd_low,
	input  wire logic         vel_limited,
	input  wire logic [7:0]   regen_factor,
	input  wire logic [7:0]   overload_factor,
	input  wire logic [7:0]   servo_state,
	output logic              regen_overload_alarm,
	output logic              overload_alarm,
	output logic      [69:0]  disp_seg,
	output logic      [9:0]   disp_dp
);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic smd_seg_t hex_seg(input logic [3:0] v);
		case (v)
			4'h0: hex_seg = 7'h3f;
			4'h1: hex_seg = 7'h06;
			4'h2: hex_seg = 7'h5b;
			4'h3: hex_seg = 7'h4f;
			4'h4: hex_seg = 7'h66;
			4'h5: hex_seg = 7'h6d;
			4'h6: hex_seg = 7'h7d;
			4'h7: hex_seg = 7'h07;
			4'h8: hex_seg = 7'h7f;
			4'h9: hex_seg = 7'h6f;
			4'ha: hex_seg = 7'h77;
			4'hb: hex_seg = 7'h7c;
			4'hc: hex_seg = 7'h39;
			4'hd: hex_seg = 7'h5e;
			4'he: hex_seg = 7'h79;
			default: hex_seg = 7'h71;
		endcase
	endfunction : hex_seg

	function automatic logic [3:0] to_bcd_tens(input logic [3:0] v);
		to_bcd_tens = (v > 4'h9) ? 4'h1 : 4'h0;
	endfunction : to_bcd_tens

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	localparam int SW = 58;
	logic [SW-1:0] sync_a;
	logic [SW-1:0] sync_b;
	logic          strobe_d;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {input_lines, output_lines, enc_position, enc_strobe,
				bus_undervoltage, servo_on_input, positive_limit_input, negative_limit_input,
				drive_alarm, relay_closed, estop_input, cmd_dir_negative, pos_cmd_low,
				torque_limited, zero_clamp_closed, vel_cmd_low, torque_cmd_low, vel_limited};
			sync_b <= sync_a;
		end
	end

	logic [9:0]  in_s;
	logic [9:0]  out_s;
	logic [22:0] pos_s;
	logic        strobe_s;
	logic [13:0] cond_s;
	assign in_s     = sync_b[57:48];
	assign out_s    = sync_b[47:38];
	assign pos_s    = sync_b[37:15];
	assign strobe_s = sync_b[14];
	assign cond_s   = sync_b[13:0];

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [5:0]               sel_pending;
	smd_item_e                view_item;
	logic                     limit_setting;
	logic                     clamp_setting;
	logic                     io_page_out;
	logic [`SMD_INT_W-1:0]    int_status;
	logic [`SMD_INT_W-1:0]    int_mask;
	logic [7:0]               regen_limit;
	logic [7:0]               overload_limit;
	logic                     view_load;
	logic [22:0]              single_turn;
	logic signed [15:0]       turn_count;
	logic [3:0]               cause;

	logic wr_en;
	logic setup;
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && pready;

	// APB answers with no wait states; read data is prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b1;
			pslverr <= 1'b0;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			case (paddr)
				`SMD_OFS_CTRL:        prdata <= {20'h0, 1'b0, io_page_out, clamp_setting, limit_setting,
					2'h0, sel_pending};
				`SMD_OFS_INT_STATUS:  prdata <= {27'h0, int_status};
				`SMD_OFS_INT_MASK:    prdata <= {27'h0, int_mask};
				`SMD_OFS_SINGLE_TURN: prdata <= {9'h0, single_turn};
				`SMD_OFS_TURN_COUNT:  prdata <= {{16{turn_count[15]}}, turn_count};
				`SMD_OFS_CAUSE:       prdata <= {28'h0, cause};
				`SMD_OFS_LOAD:        prdata <= {14'h0, overload_alarm, regen_overload_alarm,
					overload_factor, regen_factor};
				`SMD_OFS_LOAD_LIMIT:  prdata <= {16'h0, overload_limit, regen_limit};
				`SMD_OFS_VIEW:        prdata <= {26'h0, view_item};
				default: begin
					prdata  <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
			endcase
		end
	end

	// Control fields; the selection only reaches the view on a restart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_pending   <= `SMD_SEL_DEFAULT;
			limit_setting <= 1'b0;
			clamp_setting <= 1'b0;
			io_page_out   <= 1'b0;
			view_load     <= 1'b1;
		end else begin
			view_load <= 1'b0;
			if (wr_en && paddr == `SMD_OFS_CTRL) begin
				if (pwdata[`SMD_CTRL_SEL_MSB:`SMD_CTRL_SEL_LSB] <= `SMD_SEL_MAX)
					sel_pending <= pwdata[`SMD_CTRL_SEL_MSB:`SMD_CTRL_SEL_LSB];
				limit_setting <= pwdata[`SMD_CTRL_LIMIT_BIT];
				clamp_setting <= pwdata[`SMD_CTRL_CLAMP_BIT];
				io_page_out   <= pwdata[`SMD_CTRL_IOPAGE_BIT];
				view_load     <= pwdata[`SMD_CTRL_RESTART];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			view_item <= SMD_ITEM_SERVO;
		end else if (view_load) begin
			view_item <= smd_item_e'(sel_pending);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask       <= '0;
			regen_limit    <= `SMD_LIMIT_DEFAULT;
			overload_limit <= `SMD_LIMIT_DEFAULT;
		end else if (wr_en) begin
			if (paddr == `SMD_OFS_INT_MASK)
				int_mask <= pwdata[`SMD_INT_W-1:0];
			if (paddr == `SMD_OFS_LOAD_LIMIT) begin
				regen_limit    <= pwdata[7:0];
				overload_limit <= pwdata[15:8];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Encoder turn tracking
	// ------------------------------------------------------------------------
	logic        sample;
	logic        turn_up;
	logic        turn_down;
	logic [22:0] fwd_step;
	logic [22:0] back_step;
	assign sample    = strobe_s && !strobe_d;
	assign fwd_step  = pos_s - single_turn;
	assign back_step = single_turn - pos_s;
	// Big backward jump means the count rolled past the top going counter-clockwise
	assign turn_up   = sample && (pos_s < single_turn) && (back_step > `SMD_HALF_TURN);
	assign turn_down = sample && (pos_s > single_turn) && (fwd_step > `SMD_HALF_TURN);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_d    <= 1'b0;
			single_turn <= '0;
			turn_count  <= '0;
		end else begin
			strobe_d <= strobe_s;
			if (sample)
				single_turn <= pos_s;
			if (turn_up)
				turn_count <= turn_count + 16'sh0001;
			else if (turn_down)
				turn_count <= turn_count - 16'sh0001;
		end
	end

	// ------------------------------------------------------------------------
	// No-run cause, lowest code wins
	// ------------------------------------------------------------------------
	logic [3:0] next_cause;
	logic       cmd_dir_negative_s;
	logic       limit_open;
	assign cmd_dir_negative_s = cond_s[6];
	// Only the limit on the side the command heads for can stop the motor
	assign limit_open = cmd_dir_negative_s ? !cond_s[10] : !cond_s[11];

	// Code 11 is never produced; code 0 means nothing holds the motor
	always_comb begin
		if (cond_s[13])                           next_cause = 4'h1;
		else if (!cond_s[12])                     next_cause = 4'h2;
		else if (!limit_setting && limit_open)    next_cause = 4'h3;
		else if (cond_s[9])                       next_cause = 4'h4;
		else if (!cond_s[8])                      next_cause = 4'h5;
		else if (cond_s[7])                       next_cause = 4'h6;
		else if (cond_s[5])                       next_cause = 4'h7;
		else if (cond_s[4])                       next_cause = 4'h8;
		else if (clamp_setting && !cond_s[3])     next_cause = 4'h9;
		else if (cond_s[2])                       next_cause = 4'ha;
		else if (cond_s[1])                       next_cause = 4'hc;
		else if (cond_s[0])                       next_cause = 4'hd;
		else                                      next_cause = 4'h0;
	end

	// ------------------------------------------------------------------------
	// Load alarms and interrupt status
	// ------------------------------------------------------------------------
	logic next_regen;
	logic next_over;
	assign next_regen = regen_factor >= regen_limit;
	assign next_over  = overload_factor >= overload_limit;

	logic [`SMD_INT_W-1:0] events;
	logic [`SMD_INT_W-1:0] clr;
	assign events = {next_cause != cause, next_over && !overload_alarm,
		next_regen && !regen_overload_alarm, turn_down, turn_up};
	assign clr = (wr_en && paddr == `SMD_OFS_INT_STATUS) ? pwdata[`SMD_INT_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause                <= 4'h0;
			regen_overload_alarm <= 1'b0;
			overload_alarm       <= 1'b0;
			int_status           <= '0;
			irq                  <= 1'b0;
		end else begin
			cause                <= next_cause;
			regen_overload_alarm <= next_regen;
			overload_alarm       <= next_over;
			// Set wins over a simultaneous write-one clear
			int_status           <= (int_status & ~clr) | events;
			irq                  <= |(int_status & int_mask);
		end
	end

	// ------------------------------------------------------------------------
	// Display composition, digit 0 is rightmost
	// ------------------------------------------------------------------------
	logic [69:0] next_seg;
	logic [9:0]  next_dp;
	logic [15:0] turn_mag;
	assign turn_mag = turn_count[15] ? 16'(-turn_count) : 16'(turn_count);

	always_comb begin
		next_seg = '0;
		next_dp  = '0;
		case (view_item)
			SMD_ITEM_IO: begin
				for (int i = 0; i < `SMD_DIGITS; i++) begin
					if (!io_page_out) begin
						next_seg[i*7 +: 7] = in_s[i] ? `SMD_SEG_UPPER : `SMD_SEG_LOWER;
						next_dp[i]         = 1'b1;
					end else begin
						next_seg[i*7 +: 7] = out_s[i] ? `SMD_SEG_UPPER : `SMD_SEG_LOWER;
						next_dp[i]         = 1'b0;
					end
				end
			end
			SMD_ITEM_CAUSE: begin
				next_seg[69:63] = `SMD_SEG_C;
				next_seg[62:56] = `SMD_SEG_P;
				next_seg[13:7]  = hex_seg(to_bcd_tens(cause));
				next_seg[6:0]   = hex_seg(cause > 4'h9 ? cause - 4'ha : cause);
			end
			SMD_ITEM_SINGLE: begin
				for (int i = 0; i < 6; i++)
					next_seg[i*7 +: 7] = hex_seg(4'({1'b0, single_turn} >> (i*4)));
			end
			SMD_ITEM_TURNS: begin
				for (int i = 0; i < 4; i++)
					next_seg[i*7 +: 7] = hex_seg(4'(turn_mag >> (i*4)));
				next_dp[9] = turn_count[15];
				next_dp[8] = turn_count[15];
			end
			SMD_ITEM_SERVO: begin
				next_seg[13:7] = hex_seg(servo_state[7:4]);
				next_seg[6:0]  = hex_seg(servo_state[3:0]);
			end
			default: begin
				next_seg = '0;
				next_dp  = '0;
			end
		endcase
	end

	// Registered so the panel never sees decode glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_seg <= '0;
			disp_dp  <= '0;
		end else begin
			disp_seg <= next_seg;
			disp_dp  <= next_dp;
		end
	end

endmodule : smd_monitor
`default_nettype wire

// *** sim/smd_panel.sv ***
// Front panel model: tells which half of each digit is lit
`timescale 1ns/100ps
`default_nettype none
module smd_panel
	import smd_pkg::*;
(
	input  wire logic [69:0] disp_seg,
	input  wire logic [9:0]  disp_dp,
	output logic      [9:0]  upper,
	output logic      [9:0]  lower,
	output logic      [9:0]  points
);
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			upper[i] = (disp_seg[7*i+:7] == 7'h23);
			lower[i] = (disp_seg[7*i+:7] == 7'h1c);
		end
	end
	assign points = disp_dp;
endmodule : smd_panel
`default_nettype wire

// *** sim/smd_monitor_chk.sv ***
// Port checker for the servo monitor display block
`timescale 1ns/100ps
`default_nettype none
module smd_monitor_chk
	import smd_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [9:0]  input_lines,
	input wire logic [9:0]  output_lines,
	input wire logic [7:0]  regen_factor,
	input wire logic [7:0]  overload_factor,
	input wire logic        regen_overload_alarm,
	input wire logic        overload_alarm,
	input wire logic [69:0] disp_seg,
	input wire logic [9:0]  disp_dp
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       acc_w;
	logic [5:0] sel_p;
	logic [5:0] view_c;
	logic       page_c;
	logic [2:0] age;
	logic [7:0] lim_r;
	logic [7:0] lim_o;
	assign acc_w = psel && penable && pwrite;

	function automatic logic [69:0] halves(input logic [9:0] v);
		for (int i = 0; i < 10; i++)
			halves[7*i+:7] = v[i] ? 7'h23 : 7'h1c;
	endfunction : halves

	// Tracks the shown item and page; age lets the display settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_p  <= 6'h22;
			view_c <= 6'h22;
			page_c <= 1'b0;
			age    <= 3'h0;
		end else if (acc_w && paddr == 12'h000) begin
			sel_p  <= (pwdata[5:0] > 6'h2a) ? sel_p : pwdata[5:0];
			view_c <= !pwdata[11] ? view_c : (pwdata[5:0] > 6'h2a) ? sel_p : pwdata[5:0];
			page_c <= pwdata[10];
			age    <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim_r <= 8'h64;
			lim_o <= 8'h64;
		end else if (acc_w && paddr == 12'h01c) begin
			lim_r <= pwdata[7:0];
			lim_o <= pwdata[15:8];
		end
	end

	sequence s_in_settled;
		(age == 3'h7 && view_c == 6'h0a && !page_c && $stable(input_lines))[*5];
	endsequence
	sequence s_out_settled;
		(age == 3'h7 && view_c == 6'h0a && page_c && $stable(output_lines))[*5];
	endsequence

	a_ready_always: assert property (pready)
		else $error("pready low after reset");
	a_unmapped_error: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
		else $error("unmapped access without error");
	a_error_reads_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_io_in_halves: assert property (s_in_settled |-> disp_seg == halves(input_lines))
		else $error("input halves wrong");
	a_io_in_points: assert property (s_in_settled |-> disp_dp == 10'h3ff)
		else $error("input points dark");
	a_io_out_view: assert property (s_out_settled |-> disp_seg == halves(output_lines) && disp_dp == 10'h0)
		else $error("output view wrong");
	a_regen_alarm: assert property (($stable(regen_factor) && $stable(lim_r))[*3]
		|-> regen_overload_alarm == (regen_factor >= lim_r)) else $error("regen alarm wrong");
	a_overload_alarm: assert property (($stable(overload_factor) && $stable(lim_o))[*3]
		|-> overload_alarm == (overload_factor >= lim_o)) else $error("overload alarm wrong");
endmodule : smd_monitor_chk

bind smd_monitor smd_monitor_chk u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.input_lines, .output_lines, .regen_factor, .overload_factor, .regen_overload_alarm,
	.overload_alarm, .disp_seg, .disp_dp
);
`default_nettype wire

// *** sim/smd_monitor_tb_top.sv ***
// Self-checking bench for the servo monitor display block
`timescale 1ns/100ps
`default_nettype none
`include "smd_consts.svh"
module smd_monitor_tb_top
	import smd_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rd_e;
	logic        enc_strobe, cmd_dir_negative, nlim, regen_overload_alarm, overload_alarm;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_d;
	logic [9:0]  input_lines, output_lines, disp_dp, upper, lower, points;
	logic [22:0] enc_position;
	logic [13:1] flt;
	logic [7:0]  regen_factor, overload_factor, servo_state;
	logic [69:0] disp_seg;
	int          error_cnt, cmp_count, cyc;
	logic [22:0] ep [8] = '{23'h000100, 23'h7fff00, 23'h000080, 23'h7fffff, 23'h0, 23'h400000, 23'h0, 23'h400001};
	logic [31:0] et [8] = '{32'h0, 32'hffffffff, 32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'hffffffff};

	smd_monitor DUT (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
		.input_lines, .output_lines, .enc_position, .enc_strobe, .bus_undervoltage(flt[1]),
		.servo_on_input(!flt[2]), .positive_limit_input(!flt[3]), .negative_limit_input(nlim),
		.drive_alarm(flt[4]), .relay_closed(!flt[5]), .estop_input(flt[6]), .cmd_dir_negative,
		.pos_cmd_low(flt[7]), .torque_limited(flt[8]), .zero_clamp_closed(!flt[9]), .vel_cmd_low(flt[10]),
		.torque_cmd_low(flt[12]), .vel_limited(flt[13]), .regen_factor, .overload_factor, .servo_state,
		.regen_overload_alarm, .overload_alarm, .disp_seg, .disp_dp
	);
	smd_panel u_panel (.disp_seg, .disp_dp, .upper, .lower, .points);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// APB transfer: setup, then access held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_d = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, rd_e}, 32'(a > 12'h020));
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_d & m, e);
	endtask : rd

	initial begin
		{presetn, psel, penable, pwrite, enc_strobe, cmd_dir_negative} = '0;
		{paddr, pwdata, input_lines, output_lines, enc_position, flt} = '0;
		{regen_factor, overload_factor, error_cnt, cmp_count, cyc} = '0;
		nlim = 1'b1;
		servo_state = 8'h5a;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(`SMD_OFS_CTRL, 32'h7ff, 32'h022);
		rd(`SMD_OFS_VIEW, 32'h3f, 32'h022);
		chk({18'h0, disp_seg[13:0]}, {18'h0, 7'h6d, 7'h77});
		rd(`SMD_OFS_LOAD_LIMIT, 32'hffff, 32'h6464);
		rd(`SMD_OFS_INT_MASK, 32'h1f, 32'h0);
		rd(12'h024, 32'hffffffff, 32'h0);
		wr(`SMD_OFS_CTRL, 32'h80a);
		input_lines <= 10'h281;
		repeat (8) @(posedge pclk);
		rd(`SMD_OFS_VIEW, 32'h3f, 32'h00a);
		chk({22'h0, upper}, 32'h281);
		chk({22'h0, lower}, 32'h17e);
		chk({22'h0, points}, 32'h3ff);
		wr(`SMD_OFS_CTRL, 32'h40a);
		output_lines <= 10'h001;
		repeat (8) @(posedge pclk);
		chk({22'h0, upper}, 32'h001);
		chk({22'h0, points}, 32'h0);
		wr(`SMD_OFS_CTRL, 32'h82b);
		rd(`SMD_OFS_CTRL, 32'h3f, 32'h00a);
		wr(`SMD_OFS_CTRL, 32'h02a);
		rd(`SMD_OFS_CTRL, 32'h3f, 32'h02a);
		rd(`SMD_OFS_VIEW, 32'h3f, 32'h00a);
		wr(`SMD_OFS_CTRL, 32'h811);
		wr(`SMD_OFS_CTRL, 32'h211);
		for (int k = 1; k < 14; k++) begin
			if (k != 11) begin
				flt <= 13'h1 << (k - 1);
				repeat (5) @(posedge pclk);
				rd(`SMD_OFS_CAUSE, 32'hff, 32'(k));
			end
		end
		flt <= 13'h1004;
		repeat (5) @(posedge pclk);
		rd(`SMD_OFS_CAUSE, 32'hff, 32'h3);
		chk({25'h0, disp_seg[69:63]}, {25'h0, `SMD_SEG_C});
		cmd_dir_negative <= 1'b1;
		flt <= 13'h0004;
		repeat (5) @(posedge pclk);
		rd(`SMD_OFS_CAUSE, 32'hff, 32'h0);
		nlim <= 1'b0;
		repeat (5) @(posedge pclk);
		rd(`SMD_OFS_CAUSE, 32'hff, 32'h3);
		wr(`SMD_OFS_CTRL, 32'h111);
		flt <= 13'h0104;
		repeat (5) @(posedge pclk);
		rd(`SMD_OFS_CAUSE, 32'hff, 32'h0);
		flt <= 13'h0;
		nlim <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			enc_position <= ep[i];
			repeat (4) @(posedge pclk);
			enc_strobe <= 1'b1;
			repeat (6) @(posedge pclk);
			enc_strobe <= 1'b0;
			rd(`SMD_OFS_SINGLE_TURN, 32'h7fffff, {9'h0, ep[i]});
			rd(`SMD_OFS_TURN_COUNT, 32'hffffffff, et[i]);
		end
		wr(`SMD_OFS_CTRL, 32'h816);
		repeat (3) @(posedge pclk);
		chk({22'h0, disp_dp}, 32'h300);
		chk({25'h0, disp_seg[6:0]}, 32'h06);
		wr(`SMD_OFS_CTRL, 32'h808);
		repeat (3) @(posedge pclk);
		chk({31'h0, |{disp_seg, disp_dp}}, 32'h0);
		rd(`SMD_OFS_INT_STATUS, 32'h3, 32'h3);
		chk({31'h0, irq}, 32'h0);
		wr(`SMD_OFS_INT_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(`SMD_OFS_INT_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		rd(`SMD_OFS_INT_STATUS, 32'h3, 32'h2);
		chk({31'h0, irq}, 32'h0);
		regen_factor <= 8'd99;
		overload_factor <= 8'd49;
		wr(`SMD_OFS_LOAD_LIMIT, 32'h3264);
		rd(`SMD_OFS_LOAD, 32'h3ffff, 32'h03163);
		regen_factor <= 8'd100;
		overload_factor <= 8'd50;
		repeat (3) @(posedge pclk);
		rd(`SMD_OFS_LOAD, 32'h3ffff, 32'h33264);
		chk({30'h0, overload_alarm, regen_overload_alarm}, 32'h3);
		rd(`SMD_OFS_INT_STATUS, 32'hc, 32'hc);
		finish_test();
	end
endmodule : smd_monitor_tb_top
`default_nettype wire
